// >>> rtl/cdf_top.sv
// Card descriptor field bank: builds the 128-bit descriptor from fixed codes and
// programmable bits, keeps its 7-bit check code, and gates write/erase commands.
// Assumes an APB master on pclk and a command front end that offers one command
// per cvalid pulse.
`timescale 1ns/1ns
module cdf_top
  import cdf_pkg::*;
#(
  parameter logic [65:0] UPPER_DESC = 66'h0, // Leading descriptor fields
  parameter logic        ROM_CARD   = 1'b0   // Filesystem fields read-only
) (
  input  wire logic        pclk,      // APB clock
  input  wire logic        presetn,   // Async reset, active low
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB access phase
  input  wire logic        pwrite,    // APB write
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic             pready,    // APB ready
  output logic [31:0]      prdata,    // APB read data
  output logic             pslverr,   // APB error
  input  wire logic        cvalid,    // Command offered, one cycle
  input  wire logic        cwrite,    // Command is a block write
  input  wire logic        cerase,    // Command is an erase
  input  wire logic [11:0] clen,      // Block length of a write, bytes
  output logic             caccept,   // Command accepted pulse
  output logic             creject,   // Command refused pulse
  output logic             wr_locked  // Writes and erases inhibited
);

  logic        pready_reg,  pready_next;
  logic [31:0] prdata_reg,  prdata_next;
  logic        pslverr_reg, pslverr_next;
  logic [7:0]  prog_reg,    prog_next;
  logic [6:0]  crc_in_reg,  crc_in_next;
  logic        refused_reg, refused_next;
  logic        caccept_reg, caccept_next;
  logic        creject_reg, creject_next;
  logic        locked_reg,  locked_next;

  logic [127:0] desc;
  logic [6:0]   crc_now;
  logic [7:0]   cand;
  logic [6:0]   crc_cand;
  logic         prog_bad;
  logic         wr_commit;
  logic         rd_phase;
  logic         lifetime_lock;
  logic         temporary_lock;
  logic [31:0]  desc_word [4];

  // Descriptor bits 127..8; fixed codes are constants so no write can alter them
  function automatic logic [119:0] desc_body(input logic [7:0] p);
    desc_body = {UPPER_DESC,
                 READ_CUR_LOW_CODE,
                 READ_CUR_HIGH_CODE,
                 WRITE_CUR_LOW_CODE,
                 WRITE_CUR_HIGH_CODE,
                 CAP_MULT_EXP,
                 ERASE_UNIT_SIZE,
                 ERASE_CLUSTER_SIZE,
                 PROTECT_CLUSTER_SZ,
                 PROTECT_CLUSTER_EN,
                 SUGGESTED_ECC,
                 PROGRAM_TIME_RATIO,
                 WRITE_BLOCK_EXP,
                 PARTIAL_WRITE_FLAG,
                 DESC_RESERVED,
                 p};
  endfunction

  // Serial division by x^7 + x^3 + 1, top bit first
  function automatic logic [6:0] crc7(input logic [119:0] body);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = CRC_BODY_LEN - 1; i >= 0; i--) begin
      fb = body[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY_LOW;
      end
    end
    crc7 = c;
  endfunction

  // Shared by the error answer and the store; only this word takes writes
  function automatic logic is_prog_word(input logic [7:0] a);
    is_prog_word = (a == ADDR_PROG);
  endfunction

  always_comb begin
    crc_now = crc7(desc_body(prog_reg));
    desc    = {desc_body(prog_reg), crc_now, 1'b1};
  end

  // Host-visible descriptor words, lowest first
  for (genvar w = 0; w < 4; w++) begin : g_desc_word
    assign desc_word[w] = desc[32*w +: 32];
  end

  // Candidate content of a PROG write
  always_comb begin
    cand = prog_reg;
    cand[PROG_ECC_LSB +: 2] = pwdata[PROG_ECC_LSB +: 2];
    cand[PROG_TMP_BIT]      = pwdata[PROG_TMP_BIT];
    // One-time bits only go from 0 to 1
    cand[PROG_PERM_BIT] = prog_reg[PROG_PERM_BIT] | pwdata[PROG_PERM_BIT];
    cand[PROG_COPY_BIT] = prog_reg[PROG_COPY_BIT] | pwdata[PROG_COPY_BIT];
    if (!ROM_CARD) begin
      cand[PROG_FMT_LSB +: 2] = pwdata[PROG_FMT_LSB +: 2];
      cand[PROG_FAM_BIT]      = pwdata[PROG_FAM_BIT];
    end
    crc_cand = crc7(desc_body(cand));
    // A stale check value would leave the stored descriptor inconsistent
    prog_bad = (cand[PROG_ECC_LSB +: 2] >= ECC_FIRST_RESERVED)
             | cand[PROG_FAM_BIT]
             | (pwdata[PROG_CRC_LSB +: 7] != crc_cand);
  end

  // APB: ready one cycle into the access phase; writes land on the ready edge
  always_comb begin
    rd_phase     = psel & penable & ~pready_reg;
    wr_commit    = psel & penable & pready_reg & pwrite;
    pready_next  = rd_phase;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (rd_phase) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        ADDR_DESC0: begin
          prdata_next = desc_word[0];
        end
        ADDR_DESC1: begin
          prdata_next = desc_word[1];
        end
        ADDR_DESC2: begin
          prdata_next = desc_word[2];
        end
        ADDR_DESC3: begin
          prdata_next = desc_word[3];
        end
        ADDR_PROG: begin
          prdata_next = {17'h0, crc_in_reg, prog_reg};
        end
        ADDR_STATUS: begin
          prdata_next[STAT_INHIBIT_BIT] = locked_reg;
          prdata_next[STAT_CRC_OK_BIT]  = (crc_in_reg == crc_now);
          prdata_next[STAT_REFUSED_BIT] = refused_reg;
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
      if (pwrite) begin
        prdata_next  = 32'h0000_0000;
        // Only PROG takes writes; fixed words answer with an error
        pslverr_next = ~is_prog_word(paddr) | prog_bad;
      end
    end
  end

  always_comb begin
    prog_next    = prog_reg;
    crc_in_next  = crc_in_reg;
    refused_next = refused_reg;
    if (wr_commit && is_prog_word(paddr)) begin
      refused_next = prog_bad;
      if (!prog_bad) begin
        prog_next   = cand;
        crc_in_next = pwdata[PROG_CRC_LSB +: 7];
      end
    end
  end

  // Command gate; lifetime bit clears only on reset, so its refusal lasts until reset
  always_comb begin
    lifetime_lock  = prog_next[PROG_PERM_BIT];
    temporary_lock = prog_next[PROG_TMP_BIT];
    locked_next    = lifetime_lock | temporary_lock;
    caccept_next = 1'b0;
    creject_next = 1'b0;
    if (cvalid) begin
      if ((cwrite | cerase) && locked_reg) begin
        creject_next = 1'b1;
      end else if (cwrite && clen != WRITE_BLOCK_BYTES) begin
        creject_next = 1'b1;
      end else begin
        caccept_next = 1'b1;
      end
    end
  end

  // APB answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Customer bits are plain flops here, so they do not survive a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_reg    <= PROG_RESET;
      crc_in_reg  <= CRC_RESET;
      refused_reg <= 1'b0;
    end else begin
      prog_reg    <= prog_next;
      crc_in_reg  <= crc_in_next;
      refused_reg <= refused_next;
    end
  end

  // Command answers and lock level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      caccept_reg <= 1'b0;
      creject_reg <= 1'b0;
      locked_reg  <= 1'b0;
    end else begin
      caccept_reg <= caccept_next;
      creject_reg <= creject_next;
      locked_reg  <= locked_next;
    end
  end

  assign pready    = pready_reg;
  assign prdata    = prdata_reg;
  assign pslverr   = pslverr_reg;
  assign caccept   = caccept_reg;
  assign creject   = creject_reg;
  assign wr_locked = locked_reg;

endmodule

// >>> rtl/cdf_pkg.sv
// Constants for the card descriptor field bank: fixed codes, field layout,
// register offsets and reset values.
// Assumes a 32-bit APB master with byte addresses in paddr[7:0].
package cdf_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] ADDR_DESC0  = 8'h00;
  localparam logic [7:0] ADDR_DESC1  = 8'h04;
  localparam logic [7:0] ADDR_DESC2  = 8'h08;
  localparam logic [7:0] ADDR_DESC3  = 8'h0c;
  localparam logic [7:0] ADDR_PROG   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Fixed descriptor codes
  localparam logic [2:0] READ_CUR_LOW_CODE   = 3'h5;
  localparam logic [2:0] WRITE_CUR_LOW_CODE  = 3'h5;
  localparam logic [2:0] READ_CUR_HIGH_CODE  = 3'h5;
  localparam logic [2:0] WRITE_CUR_HIGH_CODE = 3'h5;
  localparam logic [2:0] CAP_MULT_EXP        = 3'h4;
  localparam logic [4:0] ERASE_UNIT_SIZE     = 5'h00;
  localparam logic [4:0] ERASE_CLUSTER_SIZE  = 5'h0f;
  localparam logic [4:0] PROTECT_CLUSTER_SZ  = 5'h01;
  localparam logic       PROTECT_CLUSTER_EN  = 1'b1;
  localparam logic [1:0] SUGGESTED_ECC       = 2'h0;
  localparam logic [2:0] PROGRAM_TIME_RATIO  = 3'h2;
  localparam logic [3:0] WRITE_BLOCK_EXP     = 4'h9;
  localparam logic       PARTIAL_WRITE_FLAG  = 1'b0;
  localparam logic [4:0] DESC_RESERVED       = 5'h00;
  localparam logic [11:0] WRITE_BLOCK_BYTES  = 12'h001 << WRITE_BLOCK_EXP;

  // Check code
  localparam logic [6:0] CRC_POLY_LOW = 7'h09;
  localparam int         CRC_BODY_LEN = 120;

  // Programmable field layout inside the PROG register
  localparam int PROG_ECC_LSB   = 0;
  localparam int PROG_FMT_LSB   = 2;
  localparam int PROG_TMP_BIT   = 4;
  localparam int PROG_PERM_BIT  = 5;
  localparam int PROG_COPY_BIT  = 6;
  localparam int PROG_FAM_BIT   = 7;
  localparam int PROG_CRC_LSB   = 8;
  localparam logic [1:0] ECC_FIRST_RESERVED = 2'h2;

  // Status bits
  localparam int STAT_INHIBIT_BIT = 0;
  localparam int STAT_CRC_OK_BIT  = 1;
  localparam int STAT_REFUSED_BIT = 2;

  // Reset values
  localparam logic [7:0] PROG_RESET = 8'h00;
  localparam logic [6:0] CRC_RESET  = 7'h00;

endpackage

// >>> tb/cdf_monitor.sv
// Port checker for the descriptor bank.
// Assumes it is bound onto cdf_top, one clock domain.
`timescale 1ns/1ns
module cdf_monitor
  import cdf_pkg::*;
(
  input wire logic        pclk,      // Clock
  input wire logic        presetn,   // Reset, active low
  input wire logic        psel,      // APB select
  input wire logic        penable,   // APB access
  input wire logic        pwrite,    // APB write
  input wire logic [7:0]  paddr,     // APB address
  input wire logic [31:0] pwdata,    // APB write data
  input wire logic        pready,    // APB ready
  input wire logic [31:0] prdata,    // APB read data
  input wire logic        pslverr,   // APB error
  input wire logic        cvalid,    // Command offered
  input wire logic        cwrite,    // Block write
  input wire logic        cerase,    // Erase
  input wire logic [11:0] clen,      // Write length
  input wire logic        caccept,   // Accepted
  input wire logic        creject,   // Refused
  input wire logic        wr_locked  // Lock level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = psel && pready && !pwrite;
  wire wr = psel && pready && pwrite;
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready not a single pulse after one wait");
  a_word1_fixed: assert property (rd && paddr == ADDR_DESC1 |->
    prdata[29:0] == {3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 5'h00, 5'h0f, 5'h01}) else $error("upper fixed codes wrong");
  a_word0_fixed: assert property (rd && paddr == ADDR_DESC0 |->
    prdata[31:16] == {1'b1, 2'h0, 3'h2, 4'h9, 1'b0, 5'h00} && prdata[0]) else $error("lower fixed codes wrong");
  a_fixed_no_write: assert property (wr && paddr != ADDR_PROG |-> pslverr)
    else $error("write outside programmable word not refused");
  a_bad_code_refused: assert property (wr && paddr == ADDR_PROG && (pwdata[1] || pwdata[7]) |-> pslverr)
    else $error("reserved code accepted");
  a_one_answer: assert property (cvalid |=> caccept != creject)
    else $error("command not answered exactly once");
  a_no_stray: assert property (!cvalid |=> !caccept && !creject)
    else $error("answer without command");
  a_len_reject: assert property (cvalid && cwrite && clen != 12'h200 |=> creject)
    else $error("partial block write accepted");
  a_lock_reject: assert property (cvalid && (cwrite || cerase) && wr_locked |=> creject)
    else $error("write or erase accepted while locked");
  a_read_accept: assert property (cvalid && !cwrite && !cerase |=> caccept)
    else $error("read-type command refused");
  a_lock_on_prog: assert property (!(wr && paddr == ADDR_PROG && !pslverr) |=> $stable(wr_locked))
    else $error("lock level moved without an accepted programming write");
endmodule
bind cdf_top cdf_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cvalid(cvalid),
  .cwrite(cwrite), .cerase(cerase), .clen(clen), .caccept(caccept), .creject(creject), .wr_locked(wr_locked));

// >>> tb/cdf_host_model.sv
// Host-side command source for the descriptor bank.
// Assumes each command is answered one cycle after it is taken.
`timescale 1ns/1ns
module cdf_host_model (
  input  wire logic        pclk,    // Clock
  output logic             cvalid,  // Command offered
  output logic             cwrite,  // Block write
  output logic             cerase,  // Erase
  output logic [11:0]      clen,    // Write length
  input  wire logic        caccept, // Accepted
  input  wire logic        creject  // Refused
);
  initial begin
    cvalid = 1'b0;
    cwrite = 1'b0;
    cerase = 1'b0;
    clen   = 12'h000;
  end
  task send(input logic w, input logic e, input logic [11:0] n, output logic [1:0] ar);
    @(posedge pclk);
    cvalid <= 1'b1;
    cwrite <= w;
    cerase <= e;
    clen   <= n;
    @(posedge pclk);
    cvalid <= 1'b0;
    cwrite <= 1'b0;
    cerase <= 1'b0;
    // Length means nothing outside a command
    clen   <= ~n;
    @(posedge pclk);
    ar = {caccept, creject};
  endtask
endmodule

// >>> tb/card_descriptor_fields_tb.sv
// Self-checking bench for the descriptor bank.
// Assumes APB answers with one wait state; commands go via the host model.
`timescale 1ns/1ns
module card_descriptor_fields_tb;
  import cdf_pkg::*;
  localparam logic [45:0] FIX = {3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 5'h00, 5'h0f, 5'h01, 1'b1, 2'h0, 3'h2, 4'h9, 1'b0, 5'h00};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, cvalid, cwrite, cerase, caccept, creject, wr_locked, e;
  logic [11:0] clen;
  logic [1:0]  ar;
  int          err_count = 0, checks_done = 0, cyc = 0;
  always #10 pclk = ~pclk;
  cdf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cvalid(cvalid),
    .cwrite(cwrite), .cerase(cerase), .clen(clen), .caccept(caccept), .creject(creject), .wr_locked(wr_locked));
  cdf_host_model host (.pclk(pclk), .cvalid(cvalid), .cwrite(cwrite), .cerase(cerase), .clen(clen),
    .caccept(caccept), .creject(creject));
  function automatic logic [6:0] crc7(input logic [7:0] p);
    logic [119:0] m;
    logic [6:0]   c;
    m = {66'h0, FIX, p};
    c = 7'h00;
    for (int i = 119; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  task ck(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("FAIL %s expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) ck("pready", 1, 0);
  endtask
  // Host always sends a check worked out over content q
  task wp(input logic [7:0] p, input logic [7:0] q);
    apb(1'b1, ADDR_PROG, {17'h0, crc7(q), p});
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_DESC1, 0); ck("desc1", {2'b00, FIX[45:16]}, r);
    apb(0, ADDR_DESC0, 0); ck("desc0", {FIX[15:0], 8'h00, crc7(8'h00), 1'b1}, r);
    apb(0, 8'h18, 0); ck("unmapped", 1, e);
    apb(1, ADDR_DESC1, 32'hffffffff); ck("ro write", 1, e);
    apb(0, ADDR_DESC1, 0); ck("desc1 kept", {2'b00, FIX[45:16]}, r);
    $display("fixed field test done");
    wp(8'h02, 8'h02); ck("ecc code 2", 1, e);
    wp(8'h80, 8'h80); ck("family 1", 1, e);
    apb(1, ADDR_PROG, {17'h0, ~crc7(8'h49), 8'h49}); ck("bad check", 1, e);
    apb(0, ADDR_STATUS, 0); ck("refused flag", 1, r[2]);
    wp(8'h49, 8'h49); ck("good write", 0, e);
    apb(0, ADDR_DESC0, 0); ck("desc0 prog", {FIX[15:0], 8'h49, crc7(8'h49), 1'b1}, r);
    ck("desc0 error", 0, e);
    apb(0, ADDR_STATUS, 0); ck("status", 32'h2, r);
    wp(8'h09, 8'h49); apb(0, ADDR_PROG, 0); ck("copy kept", 1, r[6]);
    $display("programmable field test done");
    host.send(1, 0, 12'h200, ar); ck("write 512", 2'b10, ar);
    host.send(1, 0, 12'h100, ar); ck("write 256", 2'b01, ar);
    host.send(0, 1, 12'h000, ar); ck("erase", 2'b10, ar);
    wp(8'h59, 8'h59); apb(0, ADDR_STATUS, 0); ck("tmp locked", 1, r[0]);
    ck("lock pin on", 1, wr_locked);
    host.send(1, 0, 12'h200, ar); ck("tmp write", 2'b01, ar);
    host.send(0, 1, 12'h000, ar); ck("tmp erase", 2'b01, ar);
    host.send(0, 0, 12'h000, ar); ck("tmp read", 2'b10, ar);
    wp(8'h49, 8'h49); host.send(1, 0, 12'h200, ar); ck("unlocked", 2'b10, ar);
    ck("lock pin off", 0, wr_locked);
    wp(8'h69, 8'h69); wp(8'h49, 8'h69); apb(0, ADDR_STATUS, 0); ck("perm lock", 1, r[0]);
    ck("lock pin perm", 1, wr_locked);
    host.send(0, 1, 12'h000, ar); ck("perm erase", 2'b01, ar);
    $display("command test done");
    complete_run;
  end
endmodule
